/* shared/oag_pkg.sv */
// constants and types shared by the operand address generator
package oag_pkg;
    // instruction word layout
    localparam int          WORD_W        = 16;
    localparam int          AP_W          = 16;             // address pointer width
    localparam int          DP_W          = 9;              // data page pointer width
    localparam int          OFS_W         = 7;              // direct offset width
    localparam int          OPC_HI        = 15;
    localparam int          OPC_LO        = 8;
    localparam int          MODE_BIT      = 7;              // 1 = indirect, 0 = direct
    localparam int          IDV_BIT       = 6;
    localparam int          INC_BIT       = 5;
    localparam int          DEC_BIT       = 4;
    localparam int          SHORT8_W      = 8;
    localparam int          SHORT9_W      = 9;
    localparam int          SHORT13_W     = 13;
    localparam int          ACC_W         = 32;
    localparam int          ADD_SHIFT     = 8;              // add-with-shift amount
    localparam int          STACK_DEPTH   = 4;              // micro call stack entries
    localparam int          SP_W          = 2;
    localparam logic [1:0]  PC_STEP_LONG  = 2'h2;           // two-word instruction advance
    localparam logic [15:0] AP_RESET      = 16'h0000;
    localparam logic [31:0] ACC_RESET     = 32'h00000000;

    // operation requested by the decoder
    typedef enum logic [3:0] {
        OAG_OP_NONE       = 4'h0,
        OAG_OP_ADD_IND    = 4'h1,  // add memory shifted, indirect
        OAG_OP_ADD_SHORT  = 4'h2,  // add 8-bit constant
        OAG_OP_ADD_LONG   = 4'h3,  // add 16-bit constant in second word
        OAG_OP_MOVE_LONG  = 4'h4,  // block move, source from second word
        OAG_OP_MOVE_BMA   = 4'h5,  // block move, source from block move register
        OAG_OP_OR_MASK    = 4'h6   // or mask register into memory word
    } oag_op_type;

    // main sequencer, gray codes along the usual path
    typedef enum logic [2:0] {
        OAG_IDLE  = 3'b000,
        OAG_READ  = 3'b001,
        OAG_EXEC  = 3'b011,
        OAG_WRITE = 3'b010,
        OAG_DONE  = 3'b110
    } oag_state_type;
endpackage

/* hdl/oag_ptr_update.sv */
// pointer update unit: linear and reverse-carry index arithmetic
`timescale 1ns/100ps
module oag_ptr_update
(
    // modifier field and operands
    input  wire logic [2:0]                 modField,
    input  wire logic [oag_pkg::AP_W-1:0]   curPtr,
    input  wire logic [oag_pkg::AP_W-1:0]   indexStep,
    // result
    output logic      [oag_pkg::AP_W-1:0]   newPtr,
    output logic                            reservedMod
);
    logic [oag_pkg::AP_W-1:0] revCur;   // pointer with bit order mirrored
    logic [oag_pkg::AP_W-1:0] revIdx;   // index with bit order mirrored
    logic [oag_pkg::AP_W-1:0] revSum;
    logic [oag_pkg::AP_W-1:0] revDif;
    logic [oag_pkg::AP_W-1:0] rcAdd;
    logic [oag_pkg::AP_W-1:0] rcSub;

    // mirroring both words lets an ordinary adder carry from msb toward lsb
    genvar b;
    generate
        for (b = 0; b < oag_pkg::AP_W; b++)
        begin : g_mirror
            assign revCur[b] = curPtr[oag_pkg::AP_W-1-b];
            assign revIdx[b] = indexStep[oag_pkg::AP_W-1-b];
            assign rcAdd[b]  = revSum[oag_pkg::AP_W-1-b];
            assign rcSub[b]  = revDif[oag_pkg::AP_W-1-b];
        end
    endgenerate

    // carry out of the mirrored top is dropped, so nothing wraps past bit zero
    assign revSum = revCur + revIdx;
    assign revDif = revCur - revIdx;

    // modifier decode: idv, inc, dec
    always_comb
    begin
        reservedMod = 1'b0;
        unique case (modField)
            3'b000:  newPtr = curPtr;                       // no change
            3'b001:  newPtr = curPtr - 16'h0001;
            3'b010:  newPtr = curPtr + 16'h0001;
            3'b011:                                         // inc and dec together
            begin
                newPtr      = curPtr;
                reservedMod = 1'b1;
            end
            3'b100:  newPtr = rcSub;
            3'b101:  newPtr = curPtr - indexStep;
            3'b110:  newPtr = curPtr + indexStep;
            3'b111:  newPtr = rcAdd;
        endcase
    end
endmodule

/* hdl/oag_core.sv */
// operand address generator: indirect, immediate and dedicated-register forms
`timescale 1ns/100ps

module oag_core
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // decoder request
    input  wire logic                        instrValid,
    input  wire oag_pkg::oag_op_type         instrOp,
    input  wire logic [oag_pkg::WORD_W-1:0]  instrWord,
    input  wire logic [oag_pkg::WORD_W-1:0]  instrWord2,
    input  wire logic [7:0]                  repeatCount,
    // shared cpu state used by this block
    input  wire logic [oag_pkg::DP_W-1:0]    dataPage,
    input  wire logic [oag_pkg::AP_W-1:0]    index_step_register,
    input  wire logic [oag_pkg::AP_W-1:0]    block_move_address_reg,
    input  wire logic [oag_pkg::WORD_W-1:0]  bit_mask_operand_reg,
    input  wire logic [oag_pkg::WORD_W-1:0]  pointerLoad,
    input  wire logic                        pointerLoadEn,
    input  wire logic [oag_pkg::WORD_W-1:0]  programCounterIn,
    // memory read data
    input  wire logic [oag_pkg::WORD_W-1:0]  dataReadBus,
    input  wire logic [oag_pkg::WORD_W-1:0]  progReadBus,
    // status
    output logic                             busy,
    output logic                             done,
    output logic                             reservedSeen,
    // data side
    output logic [oag_pkg::WORD_W-1:0]       data_address_bus,
    output logic                             dataRead,
    output logic                             dataWrite,
    output logic [oag_pkg::WORD_W-1:0]       dataWriteBus,
    // program side
    output logic [oag_pkg::WORD_W-1:0]       program_address_bus,
    output logic                             progRead,
    // architectural results
    output logic [oag_pkg::AP_W-1:0]         address_pointer_reg,
    output logic [oag_pkg::ACC_W-1:0]        accumulator_reg,
    output logic [oag_pkg::WORD_W-1:0]       prefetch_counter,
    output logic [oag_pkg::WORD_W-1:0]       programCounter
);
    oag_pkg::oag_state_type stateReg;                      // sequencer
    oag_pkg::oag_op_type    opReg;                         // latched operation
    logic [oag_pkg::WORD_W-1:0] wordReg;                   // latched first word
    logic [oag_pkg::WORD_W-1:0] word2Reg;                  // latched second word
    logic [oag_pkg::WORD_W-1:0] operandReg;                // fetched source word
    logic [7:0]                 repLeftReg;                // remaining repeats
    logic [oag_pkg::WORD_W-1:0] micro_call_stack [oag_pkg::STACK_DEPTH];
    logic [oag_pkg::SP_W-1:0]   stackPtrReg;               // next free slot
    logic [oag_pkg::AP_W-1:0]   ptrNext;                   // updated pointer
    logic                       ptrReserved;
    logic [oag_pkg::WORD_W-1:0] directAddr;                // page plus offset
    logic                       isMove;
    logic                       isLong2;                   // borrows prefetch path
    logic [oag_pkg::SP_W-1:0]   popIdx;
    logic [15:0]                repeatSpan;                // requested repeats

    // pointer arithmetic lives in its own unit
    oag_ptr_update u_ptr
    (
        .modField    (wordReg[oag_pkg::IDV_BIT:oag_pkg::DEC_BIT]),
        .curPtr      (address_pointer_reg),
        .indexStep   (index_step_register),
        .newPtr      (ptrNext),
        .reservedMod (ptrReserved)
    );

    // second operand address from the direct form of the first word
    assign directAddr = {dataPage, wordReg[oag_pkg::OFS_W-1:0]};
    assign isMove     = (opReg == oag_pkg::OAG_OP_MOVE_LONG) || (opReg == oag_pkg::OAG_OP_MOVE_BMA);
    assign isLong2    = isMove;
    assign popIdx     = stackPtrReg - 2'h1;

    // sequencer: idle, read, exec, optional write, done
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stateReg <= oag_pkg::OAG_IDLE;
        else
        begin
            unique case (stateReg)
                oag_pkg::OAG_IDLE:
                    if (instrValid && instrOp != oag_pkg::OAG_OP_NONE)
                        stateReg <= oag_pkg::OAG_READ;
                oag_pkg::OAG_READ:
                    stateReg <= oag_pkg::OAG_EXEC;
                oag_pkg::OAG_EXEC:
                    if (isMove || opReg == oag_pkg::OAG_OP_OR_MASK)
                        stateReg <= oag_pkg::OAG_WRITE;
                    else
                        stateReg <= oag_pkg::OAG_DONE;
                oag_pkg::OAG_WRITE:
                    // a repeated move loops back for the next word
                    if (isMove && repLeftReg != 8'h00)
                        stateReg <= oag_pkg::OAG_READ;
                    else
                        stateReg <= oag_pkg::OAG_DONE;
                oag_pkg::OAG_DONE:
                    stateReg <= oag_pkg::OAG_IDLE;
                default:
                    stateReg <= oag_pkg::OAG_IDLE;
            endcase
        end
    end

    // request capture; a new request is only taken in idle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            opReg    <= oag_pkg::OAG_OP_NONE;
            wordReg  <= 16'h0000;
            word2Reg <= 16'h0000;
        end
        else if (stateReg == oag_pkg::OAG_IDLE && instrValid)
        begin
            opReg    <= instrOp;
            wordReg  <= instrWord;
            word2Reg <= instrWord2;
        end
    end

    // repeat counter, reloaded per request and stepped per written word
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            repLeftReg <= 8'h00;
        else if (stateReg == oag_pkg::OAG_IDLE && instrValid)
            repLeftReg <= repeatCount;
        else if (stateReg == oag_pkg::OAG_WRITE && repLeftReg != 8'h00)
            repLeftReg <= repLeftReg - 8'h01;
    end

    // prefetch counter and micro call stack
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prefetch_counter <= 16'h0000;
            stackPtrReg      <= 2'h0;
            for (int i = 0; i < oag_pkg::STACK_DEPTH; i++)
                micro_call_stack[i] <= 16'h0000;
        end
        else if (stateReg == oag_pkg::OAG_IDLE && instrValid &&
                 (instrOp == oag_pkg::OAG_OP_MOVE_LONG || instrOp == oag_pkg::OAG_OP_MOVE_BMA))
        begin
            // save the fetch position, then borrow the counter as a pointer
            micro_call_stack[stackPtrReg] <= prefetch_counter;
            stackPtrReg                   <= stackPtrReg + 2'h1;
            if (instrOp == oag_pkg::OAG_OP_MOVE_LONG)
                prefetch_counter <= instrWord2;
            else
                prefetch_counter <= block_move_address_reg;
        end
        else if (stateReg == oag_pkg::OAG_WRITE && isMove && repLeftReg != 8'h00)
            prefetch_counter <= prefetch_counter + 16'h0001;
        else if (stateReg == oag_pkg::OAG_DONE && isLong2)
        begin
            prefetch_counter <= micro_call_stack[popIdx];
            stackPtrReg      <= popIdx;
        end
    end

    // program counter: one word for short forms, two for the long add and for both moves
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            programCounter <= 16'h0000;
        else if (stateReg == oag_pkg::OAG_DONE)
        begin
            if (isLong2 || opReg == oag_pkg::OAG_OP_ADD_LONG)
                programCounter <= programCounterIn + {14'h0000, oag_pkg::PC_STEP_LONG};
            else
                programCounter <= programCounterIn + 16'h0001;
        end
    end

    // offset of the destination within a repeated move
    function automatic logic [6:0] repCount();
        return 7'(repeatSpan - {8'h00, repLeftReg});
    endfunction

    // repeat count latched with the request, so the offset survives the countdown
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            repeatSpan <= 16'h0000;
        else if (stateReg == oag_pkg::OAG_IDLE && instrValid)
            repeatSpan <= {8'h00, repeatCount};
    end

    // address buses and strobes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            data_address_bus    <= 16'h0000;
            dataRead            <= 1'b0;
            program_address_bus <= 16'h0000;
            progRead            <= 1'b0;
        end
        else
        begin
            dataRead <= 1'b0;
            progRead <= 1'b0;
            if (stateReg == oag_pkg::OAG_IDLE && instrValid)
            begin
                unique case (instrOp)
                    oag_pkg::OAG_OP_ADD_IND:
                    begin
                        data_address_bus <= address_pointer_reg;
                        dataRead         <= 1'b1;
                    end
                    oag_pkg::OAG_OP_OR_MASK:
                    begin
                        data_address_bus <= {dataPage, instrWord[oag_pkg::OFS_W-1:0]};
                        dataRead         <= 1'b1;
                    end
                    oag_pkg::OAG_OP_MOVE_LONG:
                    begin
                        program_address_bus <= instrWord2;
                        progRead            <= 1'b1;
                    end
                    oag_pkg::OAG_OP_MOVE_BMA:
                    begin
                        program_address_bus <= block_move_address_reg;
                        progRead            <= 1'b1;
                    end
                    default:
                    begin
                        dataRead <= 1'b0;                                      // immediates touch no memory
                    end
                endcase
            end
            else if (stateReg == oag_pkg::OAG_WRITE && isMove && repLeftReg != 8'h00)
            begin
                // next repeated source word comes from the incremented counter
                program_address_bus <= prefetch_counter + 16'h0001;
                progRead            <= 1'b1;
            end
            else if (stateReg == oag_pkg::OAG_EXEC && (isMove || opReg == oag_pkg::OAG_OP_OR_MASK))
                data_address_bus <= isMove ? directAddr + {9'h000, 7'(repCount())} : directAddr;
        end
    end

    // source operand capture; progRead data for moves, dataRead for the rest
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            operandReg <= 16'h0000;
        else if (stateReg == oag_pkg::OAG_READ)
            operandReg <= isMove ? progReadBus : dataReadBus;
    end

    // write path: moves copy, mask op writes the or result back
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dataWrite    <= 1'b0;
            dataWriteBus <= 16'h0000;
        end
        else
        begin
            dataWrite <= 1'b0;
            if (stateReg == oag_pkg::OAG_EXEC && isMove)
            begin
                dataWrite    <= 1'b1;
                dataWriteBus <= operandReg;
            end
            else if (stateReg == oag_pkg::OAG_EXEC && opReg == oag_pkg::OAG_OP_OR_MASK)
            begin
                dataWrite    <= 1'b1;
                dataWriteBus <= operandReg | bit_mask_operand_reg;
            end
        end
    end

    // accumulator: shifted memory, short and long constants
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            accumulator_reg <= oag_pkg::ACC_RESET;
        else if (stateReg == oag_pkg::OAG_EXEC)
        begin
            unique case (opReg)
                oag_pkg::OAG_OP_ADD_IND:
                    accumulator_reg <= accumulator_reg +
                        ({16'h0000, operandReg} << oag_pkg::ADD_SHIFT);
                oag_pkg::OAG_OP_ADD_SHORT:
                    accumulator_reg <= accumulator_reg +
                        {24'h000000, wordReg[oag_pkg::SHORT8_W-1:0]};
                oag_pkg::OAG_OP_ADD_LONG:
                    accumulator_reg <= accumulator_reg + {16'h0000, word2Reg};
                default:
                    accumulator_reg <= accumulator_reg;
            endcase
        end
    end

    // pointer: updated after the operand access, or loaded by the cpu
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            address_pointer_reg <= oag_pkg::AP_RESET;
        else if (pointerLoadEn && stateReg == oag_pkg::OAG_IDLE)
            address_pointer_reg <= pointerLoad;
        else if (stateReg == oag_pkg::OAG_READ && opReg == oag_pkg::OAG_OP_ADD_IND &&
                 wordReg[oag_pkg::MODE_BIT])
            address_pointer_reg <= ptrNext;
    end

    // status flags
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy         <= 1'b0;
            done         <= 1'b0;
            reservedSeen <= 1'b0;
        end
        else
        begin
            busy         <= (stateReg != oag_pkg::OAG_IDLE) || instrValid;
            done         <= (stateReg == oag_pkg::OAG_DONE);
            reservedSeen <= (stateReg == oag_pkg::OAG_READ) && (opReg == oag_pkg::OAG_OP_ADD_IND)
                            && ptrReserved;
        end
    end
endmodule

/* verification/oag_core_sva.sv */
// port-level assertions for the operand address generator
`timescale 1ns/100ps
module oag_core_sva
(
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_n,
    // decoder side
    input wire logic                instrValid,
    input wire oag_pkg::oag_op_type instrOp,
    input wire logic [15:0]         instrWord,
    input wire logic [15:0]         instrWord2,
    input wire logic [7:0]          repeatCount,
    input wire logic [8:0]          dataPage,
    input wire logic [15:0]         programCounterIn,
    // observed outputs
    input wire logic                busy,
    input wire logic                done,
    input wire logic                reservedSeen,
    input wire logic [15:0]         data_address_bus,
    input wire logic                dataRead,
    input wire logic                dataWrite,
    input wire logic [15:0]         program_address_bus,
    input wire logic                progRead,
    input wire logic [15:0]         programCounter
);
    // request accepted while idle; bench holds op and words until done
    logic take;
    assign take = instrValid && !busy && (instrOp != oag_pkg::OAG_OP_NONE);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    done_in_time_a: assert property (take && repeatCount == 8'h00 |-> ##[3:6] done)
        else $error("done late");
    done_single_a: assert property (done |=> !done) else $error("done too long");
    rsv_single_a: assert property (reservedSeen |=> !reservedSeen)
        else $error("reserved flag too long");
    rsv_cause_a: assert property (reservedSeen |-> instrWord[6:4] == 3'b011)
        else $error("reserved flag without cause");
    long_no_read_a: assert property (take && instrOp == oag_pkg::OAG_OP_ADD_LONG |-> !dataRead [*5])
        else $error("long add touched data memory");
    page_addr_a: assert property (dataWrite && instrOp == oag_pkg::OAG_OP_MOVE_LONG && repeatCount == 8'h00
        |-> data_address_bus == {dataPage, instrWord[6:0]}) else $error("bad direct address");
    prog_addr_a: assert property (progRead && instrOp == oag_pkg::OAG_OP_MOVE_LONG && repeatCount == 8'h00
        |-> program_address_bus == instrWord2) else $error("bad program address");
    pc_two_a: assert property (done && instrOp inside {oag_pkg::OAG_OP_ADD_LONG, oag_pkg::OAG_OP_MOVE_LONG}
        |-> programCounter == programCounterIn + 16'h0002) else $error("pc not advanced by two");
    write_busy_a: assert property (dataWrite |-> busy) else $error("write while idle");
endmodule

bind oag_core oag_core_sva u_sva (.clk, .rst_n, .instrValid, .instrOp, .instrWord, .instrWord2, .repeatCount,
    .dataPage, .programCounterIn, .busy, .done, .reservedSeen, .data_address_bus, .dataRead, .dataWrite,
    .program_address_bus, .progRead, .programCounter);

/* verification/testbench.sv */
// self-checking bench for the operand address generator
`timescale 1ns/100ps
module testbench;
    logic                clk, rst_n, instrValid, pointerLoadEn;
    oag_pkg::oag_op_type instrOp;
    logic [15:0]         instrWord, instrWord2, pointerLoad, programCounterIn, dataReadBus, progReadBus;
    logic [15:0]         index_step_register, block_move_address_reg, bit_mask_operand_reg;
    logic [7:0]          repeatCount;
    logic [8:0]          dataPage;
    logic                busy, done, reservedSeen, dataRead, dataWrite, progRead;
    logic [15:0]         data_address_bus, dataWriteBus, program_address_bus, address_pointer_reg;
    logic [15:0]         prefetch_counter, programCounter;
    logic [31:0]         accumulator_reg, accExp;
    logic [15:0]         rdA[$], prA[$], wrA[$], wrD[$];   // strobed addresses and write data
    int                  err_count, check_count, rsv;

    oag_core u_dut (.clk, .rst_n, .instrValid, .instrOp, .instrWord, .instrWord2, .repeatCount, .dataPage,
        .index_step_register, .block_move_address_reg, .bit_mask_operand_reg, .pointerLoad, .pointerLoadEn,
        .programCounterIn, .dataReadBus, .progReadBus, .busy, .done, .reservedSeen, .data_address_bus,
        .dataRead, .dataWrite, .dataWriteBus, .program_address_bus, .progRead, .address_pointer_reg,
        .accumulator_reg, .prefetch_counter, .programCounter);

    // free-running 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask

    function automatic logic [3:0] rev(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction

    // one instruction; strobes sampled at negedge since they stand one cycle
    task automatic run(input oag_pkg::oag_op_type op, input logic [15:0] w1, input logic [15:0] w2);
        int n;
        rdA.delete(); prA.delete(); wrA.delete(); wrD.delete();
        rsv = 0;
        n = 0;
        @(posedge clk);
        #1 instrValid = 1'b1;
        instrOp = op;
        instrWord = w1;
        instrWord2 = w2;
        @(posedge clk);
        #1 instrValid = 1'b0;
        do
        begin
            @(negedge clk);
            if (dataRead === 1'b1) rdA.push_back(data_address_bus);
            if (progRead === 1'b1) prA.push_back(program_address_bus);
            if (dataWrite === 1'b1) wrA.push_back(data_address_bus);
            if (dataWrite === 1'b1) wrD.push_back(dataWriteBus);
            if (reservedSeen === 1'b1) rsv = 1;
            n++;
        end while (done !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            err_count++;   // hang: no completion within the bound
            end_sim();
        end
        @(posedge clk);
        #1;
    endtask

    task automatic ld(input logic [15:0] p);
        @(posedge clk);
        #1 pointerLoadEn = 1'b1;
        pointerLoad = p;
        @(posedge clk);
        #1 pointerLoadEn = 1'b0;
    endtask

    // linear index steps and the reserved modifier
    task automatic t_indexed;
        ld(16'h0100);
        run(oag_pkg::OAG_OP_ADD_IND, 16'h28d0, 16'h0000);
        accExp += 32'h00001200;
        chk(rdA[0], 16'h0100);
        chk({address_pointer_reg, 16'h0000}, 32'h00f00000);
        chk(accumulator_reg, accExp);
        run(oag_pkg::OAG_OP_ADD_IND, 16'h28e0, 16'h0000);
        accExp += 32'h00001200;
        chk({rdA[0], address_pointer_reg}, 32'h00f00100);
        chk(accumulator_reg, accExp);
        run(oag_pkg::OAG_OP_ADD_IND, 16'h28b0, 16'h0000);
        accExp += 32'h00001200;   // operand is still fetched and added
        chk({rsv[15:0], address_pointer_reg}, 32'h00010100);
    endtask

    // reverse-carry walk up through all 16 steps, then back down
    task automatic t_bitrev;
        ld(16'h0060);
        index_step_register = 16'h0008;   // half of a 16-point transform
        for (int k = 1; k <= 16; k++)
        begin
            run(oag_pkg::OAG_OP_ADD_IND, 16'h28f0, 16'h0000);
            chk(address_pointer_reg, {12'h006, rev(k[3:0])});
        end
        for (int k = 15; k >= 0; k--)
        begin
            run(oag_pkg::OAG_OP_ADD_IND, 16'h28c0, 16'h0000);
            chk(address_pointer_reg, {12'h006, rev(k[3:0])});
        end
    endtask

    // short and long immediate adds
    task automatic t_immediate;
        run(oag_pkg::OAG_OP_ADD_SHORT, 16'hb9a5, 16'h0000);
        accExp += 32'h000000a5;
        chk(accumulator_reg, accExp);
        run(oag_pkg::OAG_OP_ADD_LONG, 16'hbf90, 16'h1234);
        accExp += 32'h00001234;
        chk(accumulator_reg, accExp);
        chk(programCounter, 16'h0402);
    endtask

    // two-operand move with one repeat, register-sourced move, masked or
    task automatic t_moves;
        dataPage = 9'h003;
        repeatCount = 8'h01;
        run(oag_pkg::OAG_OP_MOVE_LONG, 16'ha812, 16'h2345);
        chk({prA[0], prA[1]}, 32'h23452346);
        chk({wrA[0], wrA[1]}, 32'h01920193);
        chk({wrD[0], wrD[1]}, 32'hbeefbeef);
        chk({prefetch_counter, programCounter}, 32'h00000402);
        repeatCount = 8'h00;
        run(oag_pkg::OAG_OP_MOVE_LONG, 16'ha805, 16'h3000);
        chk({prA[0], wrA[0]}, 32'h30000185);
        dataPage = 9'h000;
        progReadBus = 16'h5a5a;
        run(oag_pkg::OAG_OP_MOVE_BMA, 16'ha864, 16'h0000);
        chk(prA[0], 16'h0200);
        chk({wrA[0], wrD[0]}, 32'h00645a5a);
        dataPage = 9'h006;
        dataReadBus = 16'h0001;
        run(oag_pkg::OAG_OP_OR_MASK, 16'hbe0a, 16'h0000);
        chk({rdA[0], wrA[0]}, 32'h030a030a);
        chk(wrD[0], 16'hfff1);
    endtask

    // main sequence: reset, scenarios, verdict
    initial
    begin
        rst_n = 1'b0;
        instrValid = 1'b0;
        instrOp = oag_pkg::OAG_OP_NONE;
        {instrWord, instrWord2, pointerLoad} = 48'h0;
        pointerLoadEn = 1'b0;
        repeatCount = 8'h00;
        dataPage = 9'h000;
        index_step_register = 16'h0010;
        block_move_address_reg = 16'h0200;
        bit_mask_operand_reg = 16'hfff0;
        programCounterIn = 16'h0400;
        dataReadBus = 16'h0012;
        progReadBus = 16'hbeef;
        {err_count, check_count, rsv} = 0;
        accExp = 32'h0;
        repeat (5) @(posedge clk);
        chk(accumulator_reg, 32'h0);
        chk({address_pointer_reg, programCounter}, 32'h0);
        #1 rst_n = 1'b1;
        t_indexed();
        dataReadBus = 16'h0000;   // keep the accumulator still during the walk
        t_bitrev();
        t_immediate();
        t_moves();
        end_sim();
    end
endmodule
